// File: src/hcv_apb_mst.sv
`timescale 1ns/1ps
module hcv_apb_mst import hcv_pkg::*; (
	input logic pclk, // System clock
	input logic presetn, // Async reset, active low
	input logic start, // Begin a transfer, taken when idle
	input logic wr, // Direction of the transfer
	input logic [31:0] addr, // Target byte address
	input logic [31:0] wdata, // Write data
	output hcv_apb_req_t bus_o, // Request toward the device
	input hcv_apb_rsp_t bus_i, // Answer from the device
	output logic done, // Transfer finished, one cycle
	output logic [31:0] rdata, // Read data of last read transfer
	output logic err // Slave error of last transfer
);
	hcv_mst_st_t st_r;
	hcv_mst_st_t st_nxt;
	hcv_apb_req_t req_r;
	hcv_apb_req_t req_nxt;
	logic done_r;
	logic done_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic err_r;
	logic err_nxt;

	// Request stays frozen until pready closes the access phase
	always_comb begin
		st_nxt = st_r;
		req_nxt = req_r;
		done_nxt = 1'b0;
		rdata_nxt = rdata_r;
		err_nxt = err_r;
		case (st_r)
			MST_IDLE: begin
				if (start) begin
					req_nxt.paddr = addr;
					req_nxt.pwrite = wr;
					req_nxt.pwdata = wdata;
					req_nxt.psel = 1'b1;
					req_nxt.penable = 1'b0;
					st_nxt = MST_SETUP;
				end
			end
			MST_SETUP: begin
				req_nxt.penable = 1'b1;
				st_nxt = MST_ACC;
			end
			MST_ACC: begin
				if (bus_i.pready) begin
					req_nxt.psel = 1'b0;
					req_nxt.penable = 1'b0;
					done_nxt = 1'b1;
					err_nxt = bus_i.pslverr;
					if (!req_r.pwrite) begin
						rdata_nxt = bus_i.prdata;
					end
					st_nxt = MST_IDLE;
				end
			end
			default: begin
				req_nxt.psel = 1'b0;
				req_nxt.penable = 1'b0;
				st_nxt = MST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= MST_IDLE;
			req_r <= '0;
			done_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			req_r <= req_nxt;
			done_r <= done_nxt;
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
		end
	end

	assign bus_o = req_r;
	assign done = done_r;
	assign rdata = rdata_r;
	assign err = err_r;

	chk_apb_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(req_r.psel && req_r.penable && !bus_i.pready) |=>
		(req_r.psel && req_r.penable && $stable(req_r.paddr) && $stable(req_r.pwrite)
		&& $stable(req_r.pwdata)))
		else $error("apb request changed before pready");

	chk_apb_setup: assert property (@(posedge pclk) disable iff (!presetn)
		(req_r.psel && !req_r.penable) |=> (req_r.psel && req_r.penable))
		else $error("apb setup not followed by access");

endmodule // hcv_apb_mst

// File: src/hcv_ctrl.sv
// Summary of operation
// - Hold code 01 5 ms between extremes
// - Wait 5 ms plus margin before fast
// - Raise voltage, enable oscillator, then switch
// - 1 MHz uses 01, 2 MHz uses 1x
// - Slow clock: supply picks 00 or 01
// - Change voltage only when supply confirmed
// - Clock back and oscillator off separately
// - Set slow voltage code right after reset
// - High supply may keep code 00
// - Idle: slow clock, oscillator off, low code
`timescale 1ns/1ps
module hcv_ctrl import hcv_pkg::*; #(
	parameter int VHOLD_CYC = VHOLD_CYC_DEF,
	parameter int OSC_CYC = OSC_CYC_DEF
) (
	input logic pclk, // System clock, 250 MHz
	input logic presetn, // Async reset, active low
	input hcv_apb_req_t s_req, // Software APB request
	output hcv_apb_rsp_t s_rsp, // Software APB answer
	output hcv_apb_req_t m_req, // Device APB request
	input hcv_apb_rsp_t m_rsp, // Device APB answer
	input logic svd_ok, // Supply detector confirms supply, async pin
	output logic busy // Sequence in progress
);
	hcv_st_t st_r;
	hcv_st_t st_nxt;
	logic kick_r;
	logic kick_nxt;
	logic [3:0] ctrl_r;
	logic [3:0] ctrl_nxt;
	logic [3:0] cur_r;
	logic [3:0] cur_nxt;
	logic [3:0] wval_r;
	logic [3:0] wval_nxt;
	logic [3:0] rb_r;
	logic [3:0] rb_nxt;
	logic err_r;
	logic err_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic slverr_r;
	logic slverr_nxt;
	logic svd_meta_r;
	logic svd_s_r;
	logic [1:0] cur_v;
	logic [1:0] tgt_v;
	logic want_fast;
	logic dec_wr;
	logic [3:0] dec_val;
	logic dec_done;
	logic dec_svd_wait;
	logic vhold_done;
	logic osc_done;
	logic mst_start;
	logic mst_wr;
	logic mst_done;
	logic mst_err;
	logic [31:0] mst_rdata;
	logic s_setup;
	logic s_wr_acc;
	logic ctrl_wr;
	logic stat_wr;
	logic [31:0] stat_val;

	function automatic logic [1:0] volt_target(input logic [3:0] c);
		logic [1:0] v;
		v = VCODE_LOW;
		if (c[CTRL_FAST_BIT]) begin
			v = c[CTRL_F2M_BIT] ? VCODE_HIGH : VCODE_MID;
		end else if (c[CTRL_SUPHI_BIT] && !c[CTRL_KEEPLOW_BIT]) begin
			v = VCODE_MID;
		end
		return v;
	endfunction

	// Next code on the way; extremes always pass the middle code
	function automatic logic [1:0] volt_step(input logic [1:0] cv, input logic [1:0] tv);
		logic [1:0] n;
		n = tv;
		if ((cv == VCODE_LOW && tv[1]) || (cv[1] && tv == VCODE_LOW)) begin
			n = VCODE_MID;
		end
		return n;
	endfunction

	// Supply detector pin is asynchronous
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			svd_meta_r <= 1'b0;
			svd_s_r <= 1'b0;
		end else begin
			svd_meta_r <= svd_ok;
			svd_s_r <= svd_meta_r;
		end
	end

	assign cur_v = cur_r[VSEL_MSB:VSEL_LSB];

	hcv_elapse #(
		.LIMIT(VHOLD_CYC)
	) u_vhold (
		.pclk(pclk),
		.presetn(presetn),
		.clear(cur_v != VCODE_MID),
		.done(vhold_done)
	);

	hcv_elapse #(
		.LIMIT(OSC_CYC)
	) u_oscwait (
		.pclk(pclk),
		.presetn(presetn),
		.clear(!cur_r[OSC_EN_BIT]),
		.done(osc_done)
	);

	hcv_apb_mst u_mst (
		.pclk(pclk),
		.presetn(presetn),
		.start(mst_start),
		.wr(mst_wr),
		.addr(DEV_OVC_ADDR),
		.wdata({28'h0000000, dec_val}),
		.bus_o(m_req),
		.bus_i(m_rsp),
		.done(mst_done),
		.rdata(mst_rdata),
		.err(mst_err)
	);

	// One device write per step, ordered by what the target needs
	always_comb begin
		tgt_v = volt_target(ctrl_r);
		want_fast = ctrl_r[CTRL_FAST_BIT];
		dec_wr = 1'b0;
		dec_val = cur_r;
		dec_done = 1'b0;
		dec_svd_wait = 1'b0;
		if (cur_r[CLK_SEL_BIT] && !want_fast) begin
			dec_wr = 1'b1;
			dec_val[CLK_SEL_BIT] = 1'b0;
		end else if (cur_r[OSC_EN_BIT] && !want_fast) begin
			dec_wr = 1'b1;
			dec_val[OSC_EN_BIT] = 1'b0;
		end else if (cur_v != tgt_v) begin
			if (!svd_s_r) begin
				dec_svd_wait = 1'b1;
			// leave the middle code only after dwell
			end else if (cur_v != VCODE_MID || vhold_done) begin
				dec_wr = 1'b1;
				dec_val[VSEL_MSB:VSEL_LSB] = volt_step(cur_v, tgt_v);
			end
		end else if (want_fast && !cur_r[OSC_EN_BIT]) begin
			dec_wr = 1'b1;
			dec_val[OSC_EN_BIT] = 1'b1;
		end else if (want_fast && !cur_r[CLK_SEL_BIT]) begin
			if (osc_done) begin
				dec_wr = 1'b1;
				dec_val[CLK_SEL_BIT] = 1'b1;
			end
		end else begin
			dec_done = 1'b1;
		end
	end

	// Software bus decode; zero wait states
	assign s_setup = s_req.psel && !s_req.penable;
	assign s_wr_acc = s_req.psel && s_req.penable && s_req.pwrite;
	assign ctrl_wr = s_wr_acc && (s_req.paddr[11:0] == CTRL_OFS);
	assign stat_wr = s_wr_acc && (s_req.paddr[11:0] == STAT_OFS);

	always_comb begin
		stat_val = 32'h0000_0000;
		stat_val[STAT_CUR_LSB +: 4] = cur_r;
		stat_val[STAT_RB_LSB +: 4] = rb_r;
		stat_val[STAT_BUSY_BIT] = (st_r != ST_IDLE);
		stat_val[STAT_SVDW_BIT] = dec_svd_wait && (st_r == ST_DECIDE);
		stat_val[STAT_ERR_BIT] = err_r;
		stat_val[STAT_SVD_BIT] = svd_s_r;
	end

	// Sequencer and register file next values
	always_comb begin
		st_nxt = st_r;
		kick_nxt = kick_r || ctrl_wr;
		ctrl_nxt = ctrl_wr ? s_req.pwdata[3:0] : ctrl_r;
		cur_nxt = cur_r;
		wval_nxt = wval_r;
		rb_nxt = rb_r;
		err_nxt = err_r;
		mst_start = 1'b0;
		mst_wr = 1'b0;
		prdata_nxt = prdata_r;
		slverr_nxt = slverr_r;
		if (stat_wr && s_req.pwdata[STAT_ERR_BIT]) begin
			err_nxt = 1'b0;
		end
		if (s_setup) begin
			slverr_nxt = 1'b0;
			if (s_req.paddr[11:0] == CTRL_OFS) begin
				prdata_nxt = {28'h0000000, ctrl_r};
			end else if (s_req.paddr[11:0] == STAT_OFS) begin
				prdata_nxt = stat_val;
			end else begin
				prdata_nxt = 32'h0000_0000;
				slverr_nxt = 1'b1;
			end
		end
		case (st_r)
			ST_IDLE: begin
				// first pass runs straight after reset
				if (kick_r) begin
					kick_nxt = ctrl_wr;
					st_nxt = ST_DECIDE;
				end
			end
			ST_DECIDE: begin
				if (dec_wr) begin
					mst_start = 1'b1;
					mst_wr = 1'b1;
					wval_nxt = dec_val;
					st_nxt = ST_WR;
				end else if (dec_done) begin
					st_nxt = ST_IDLE;
				end
			end
			ST_WR: begin
				if (mst_done) begin
					cur_nxt = wval_r;
					// A refused write is reported even if the read-back passes
					if (mst_err) begin
						err_nxt = 1'b1;
					end
					mst_start = 1'b1;
					st_nxt = ST_RD;
				end
			end
			ST_RD: begin
				if (mst_done) begin
					rb_nxt = mst_rdata[3:0];
					// Hardware set wins over a software clear
					if (mst_err || mst_rdata[3:0] != cur_r) begin
						err_nxt = 1'b1;
					end
					// Shadow follows the device, so a refused step is tried again
					if (!mst_err) begin
						cur_nxt = mst_rdata[3:0];
					end
					st_nxt = ST_DECIDE;
				end
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	// shadow starts at the device reset value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ST_IDLE;
			kick_r <= 1'b1;
			ctrl_r <= CTRL_RESET;
			cur_r <= DEV_OVC_RESET;
			wval_r <= DEV_OVC_RESET;
			rb_r <= DEV_OVC_RESET;
			err_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			slverr_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			kick_r <= kick_nxt;
			ctrl_r <= ctrl_nxt;
			cur_r <= cur_nxt;
			wval_r <= wval_nxt;
			rb_r <= rb_nxt;
			err_r <= err_nxt;
			prdata_r <= prdata_nxt;
			slverr_r <= slverr_nxt;
		end
	end

	assign s_rsp.prdata = prdata_r;
	assign s_rsp.pready = 1'b1;
	assign s_rsp.pslverr = slverr_r;
	assign busy = (st_r != ST_IDLE);

	chk_no_jump: assert property (@(posedge pclk) disable iff (!presetn)
		(m_req.psel && !m_req.penable && m_req.pwrite) |->
		!((cur_v == VCODE_LOW && m_req.pwdata[VSEL_MSB])
		|| (cur_v[1] && m_req.pwdata[VSEL_MSB:VSEL_LSB] == VCODE_LOW)))
		else $error("voltage code jumped between extremes");

	chk_mid_dwell: assert property (@(posedge pclk) disable iff (!presetn)
		(m_req.psel && !m_req.penable && m_req.pwrite && cur_v == VCODE_MID
		&& m_req.pwdata[VSEL_MSB:VSEL_LSB] != VCODE_MID) |-> vhold_done)
		else $error("middle code left before dwell time");

	chk_osc_settle: assert property (@(posedge pclk) disable iff (!presetn)
		(m_req.psel && !m_req.penable && m_req.pwrite && m_req.pwdata[CLK_SEL_BIT]
		&& !cur_r[CLK_SEL_BIT]) |-> osc_done)
		else $error("fast clock selected before settle time");

	chk_fast_order: assert property (@(posedge pclk) disable iff (!presetn)
		(m_req.psel && !m_req.penable && m_req.pwrite && m_req.pwdata[CLK_SEL_BIT]
		&& !cur_r[CLK_SEL_BIT]) |-> (cur_r[OSC_EN_BIT] && cur_v != VCODE_LOW))
		else $error("fast clock selected out of order");

	chk_split_off: assert property (@(posedge pclk) disable iff (!presetn)
		(m_req.psel && !m_req.penable && m_req.pwrite && cur_r[OSC_EN_BIT]
		&& !m_req.pwdata[OSC_EN_BIT]) |-> (!cur_r[CLK_SEL_BIT] && !m_req.pwdata[CLK_SEL_BIT]))
		else $error("oscillator stopped while still selected");

	chk_svd_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r == ST_DECIDE && !svd_s_r) |=>
		!(st_r == ST_WR && wval_r[VSEL_MSB:VSEL_LSB] != cur_v))
		else $error("voltage changed without supply confirmation");

	chk_init_pass: assert property (@(posedge pclk) disable iff (!presetn)
		(st_r == ST_IDLE && kick_r) |=> (st_r == ST_DECIDE) ##1 (st_r != ST_IDLE || !dec_wr))
		else $error("start-up pass not taken");

endmodule // hcv_ctrl

// File: src/hcv_elapse.sv
`timescale 1ns/1ps
module hcv_elapse import hcv_pkg::*; #(
	parameter int LIMIT = VHOLD_CYC_DEF
) (
	input logic pclk, // System clock
	input logic presetn, // Async reset, active low
	input logic clear, // Restart the count
	output logic done // Limit reached, level
);
	localparam int W = $clog2(LIMIT + 1);
	localparam logic [W-1:0] LIM = W'(LIMIT);

	if (LIMIT < 1) begin : g_bad_limit
		$error("hcv_elapse: LIMIT must be at least 1");
	end

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	// Saturating count so a long-settled state stays satisfied
	always_comb begin
		if (clear) begin
			cnt_nxt = '0;
		end else if (cnt_r == LIM) begin
			cnt_nxt = cnt_r;
		end else begin
			cnt_nxt = cnt_r + W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign done = (cnt_r == LIM);

	chk_clear_restart: assert property (@(posedge pclk) disable iff (!presetn)
		clear |=> !done ##0 (cnt_r == '0))
		else $error("elapse counter did not restart");

endmodule // hcv_elapse

// File: src/hcv_pkg.sv
package hcv_pkg;

	// Timing, in the units the figures are given in
	localparam int CLK_MHZ = 250;
	localparam int VHOLD_MS = 5;
	localparam int OSC_STAB_MS = 5;
	localparam int OSC_MARGIN_MS = 1;
	localparam int VHOLD_CYC_DEF = VHOLD_MS * 1000 * CLK_MHZ;
	localparam int OSC_CYC_DEF = (OSC_STAB_MS + OSC_MARGIN_MS) * 1000 * CLK_MHZ;

	// Device register oscillator_voltage_control
	localparam logic [31:0] DEV_OVC_ADDR = 32'h0000_0f70;
	localparam logic [3:0] DEV_OVC_RESET = 4'h0;
	localparam int VSEL_LSB = 0;
	localparam int VSEL_MSB = 1;
	localparam int OSC_EN_BIT = 2;
	localparam int CLK_SEL_BIT = 3;
	localparam logic [1:0] VCODE_LOW = 2'h0;
	localparam logic [1:0] VCODE_MID = 2'h1;
	localparam logic [1:0] VCODE_HIGH = 2'h2;

	// Own registers on the software side
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam int CTRL_FAST_BIT = 0;
	localparam int CTRL_F2M_BIT = 1;
	localparam int CTRL_SUPHI_BIT = 2;
	localparam int CTRL_KEEPLOW_BIT = 3;
	localparam int STAT_CUR_LSB = 0;
	localparam int STAT_RB_LSB = 4;
	localparam int STAT_BUSY_BIT = 8;
	localparam int STAT_SVDW_BIT = 9;
	localparam int STAT_ERR_BIT = 10;
	localparam int STAT_SVD_BIT = 11;

	typedef struct packed {
		logic [31:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} hcv_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} hcv_apb_rsp_t;

	typedef enum logic [2:0] {
		MST_IDLE = 3'b001,
		MST_SETUP = 3'b010,
		MST_ACC = 3'b100
	} hcv_mst_st_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_DECIDE = 4'b0010,
		ST_WR = 4'b0100,
		ST_RD = 4'b1000
	} hcv_st_t;

endpackage

// File: tb/hcv_dev_model.sv
`timescale 1ns/1ps
module hcv_dev_model import hcv_pkg::*; #(
	parameter int VHOLD_CYC = 20,
	parameter int OSC_CYC = 30
) (
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input hcv_apb_req_t req, // Request from the controller
	output hcv_apb_rsp_t rsp, // Answer to the controller
	input wire logic [3:0] lag, // Wait states before pready
	input wire logic fault, // Answer every transfer with an error
	input wire logic svd_ok, // Supply confirmed by the detector
	output logic [3:0] ovc_r, // Register content
	output logic [7:0] viol_r // Ordering faults seen on writes
);
	logic [3:0] wait_r;
	int hold_r;
	int osc_r;
	logic [3:0] nv;
	logic wr_ok;
	logic bad;
	assign nv = req.pwdata[3:0];
	assign wr_ok = req.psel && req.penable && rsp.pready && req.pwrite && !rsp.pslverr;
	// Stalled or idle bus shows inverted data, so a stale value never passes
	always_comb begin
		rsp.pready = req.psel && req.penable && (wait_r >= lag);
		rsp.pslverr = rsp.pready && (fault || req.paddr != DEV_OVC_ADDR);
		rsp.prdata = rsp.pready ? {28'h0, ovc_r} : ~{28'h0, ovc_r};
	end
	assign bad = (ovc_r[1:0] == 2'h0 && nv[1]) || (ovc_r[1] && nv[1:0] == 2'h0)
		|| (ovc_r[1:0] == 2'h1 && nv[1:0] != 2'h1 && hold_r < VHOLD_CYC)
		|| (nv[3] && !ovc_r[3] && (!ovc_r[2] || osc_r < OSC_CYC || ovc_r[1:0] == 2'h0))
		|| (nv[3] != ovc_r[3] && nv[2] != ovc_r[2])
		|| (nv[1:0] != ovc_r[1:0] && !svd_ok);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovc_r <= 4'h0;
			wait_r <= 4'h0;
			hold_r <= 0;
			osc_r <= 0;
			viol_r <= 8'h0;
		end else begin
			wait_r <= (req.psel && req.penable && !rsp.pready) ? wait_r + 4'h1 : 4'h0;
			hold_r <= (hold_r < VHOLD_CYC) ? hold_r + 1 : hold_r;
			osc_r <= (ovc_r[2] && osc_r < OSC_CYC) ? osc_r + 1 : osc_r;
			if (wr_ok) begin
				// Fields kept and read back as written
				ovc_r <= nv;
				if (nv[1:0] != ovc_r[1:0]) hold_r <= 0;
				if (!ovc_r[2]) osc_r <= 0;
				viol_r <= viol_r + {7'h0, bad};
			end
		end
	end
endmodule // hcv_dev_model

// File: tb/tb_hcv_ctrl.sv
`timescale 1ns/1ps
module tb_hcv_ctrl import hcv_pkg::*;;
	localparam int VH = 20;
	localparam int OC = 30;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	hcv_apb_req_t s_req = '0;
	hcv_apb_rsp_t s_rsp;
	hcv_apb_req_t m_req;
	hcv_apb_rsp_t m_rsp;
	logic svd_ok = 1'b1;
	logic busy;
	logic [3:0] lag = 4'h0;
	logic fault = 1'b0;
	logic [3:0] ovc;
	logic [7:0] viol;
	logic [31:0] rd;
	logic se;
	int err_total = 0;
	int samples_checked = 0;
	int cyc = 0;

	hcv_ctrl #(.VHOLD_CYC(VH), .OSC_CYC(OC)) dut_u (.pclk(pclk), .presetn(presetn),
		.s_req(s_req), .s_rsp(s_rsp), .m_req(m_req), .m_rsp(m_rsp), .svd_ok(svd_ok),
		.busy(busy));
	hcv_dev_model #(.VHOLD_CYC(VH), .OSC_CYC(OC)) dev_u (.pclk(pclk), .presetn(presetn),
		.req(m_req), .rsp(m_rsp), .lag(lag), .fault(fault), .svd_ok(svd_ok),
		.ovc_r(ovc), .viol_r(viol));

	// Clock, 4 ns period
	initial begin
		forever #2 pclk = ~pclk;
	end
	// Hang guard, far above the slowest sequence
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			test_done();
		end
	end

	task automatic test_done();
		$display("Checks %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; held until pready is seen high at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		s_req <= '{paddr: {20'h0, a}, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
		@(posedge pclk);
		s_req.penable <= 1'b1;
		do @(posedge pclk); while (s_rsp.pready !== 1'b1);
		rd = s_rsp.prdata;
		se = s_rsp.pslverr;
		s_req.psel <= 1'b0;
		s_req.penable <= 1'b0;
	endtask

	// Give the kick time to land, then wait for the sequence to end
	task automatic settle();
		repeat (4) @(posedge pclk);
		while (busy !== 1'b0) @(posedge pclk);
	endtask

	task automatic go(input logic [3:0] ctrl, input logic [3:0] dev);
		apb(1'b1, CTRL_OFS, {28'h0, ctrl});
		settle();
		cmp("device register", {28'h0, dev}, {28'h0, ovc});
		apb(1'b0, STAT_OFS, 32'h0);
		cmp("status shadow", {24'h0, dev, dev}, {24'h0, rd[7:0]});
		cmp("status error", 32'h0, {31'h0, rd[STAT_ERR_BIT]});
		cmp("order faults", 32'h0, {24'h0, viol});
	endtask

	task automatic t_reset();
		settle();
		cmp("device after reset", 32'h0, {28'h0, ovc});
		apb(1'b0, STAT_OFS, 32'h0);
		cmp("status after reset", 32'h800, {20'h0, rd[11:0]});
		$display("test reset done");
	endtask

	task automatic t_unmapped();
		apb(1'b1, 12'h008, 32'hf);
		cmp("unmapped write error", 32'h1, {31'h0, se});
		apb(1'b0, 12'h008, 32'h0);
		cmp("unmapped read data", 32'h0, rd);
		apb(1'b0, CTRL_OFS, 32'h0);
		cmp("control untouched", 32'h0, rd);
		$display("test unmapped done");
	endtask

	task automatic t_speeds();
		lag <= 4'h3;
		go(4'h7, 4'he);
		lag <= 4'h0;
		go(4'h4, 4'h1);
		go(4'hc, 4'h0);
		go(4'h1, 4'hd);
		go(4'h3, 4'he);
		go(4'h0, 4'h0);
		$display("test speeds done");
	endtask

	task automatic t_supply();
		svd_ok <= 1'b0;
		apb(1'b1, CTRL_OFS, 32'h4);
		repeat (40) @(posedge pclk);
		cmp("voltage held", 32'h0, {28'h0, ovc});
		apb(1'b0, STAT_OFS, 32'h0);
		cmp("waiting for supply", 32'h1, {31'h0, rd[STAT_SVDW_BIT]});
		svd_ok <= 1'b1;
		settle();
		cmp("voltage after supply", 32'h1, {28'h0, ovc});
		$display("test supply done");
	endtask

	task automatic t_fault();
		fault <= 1'b1;
		apb(1'b1, CTRL_OFS, 32'h0);
		do @(posedge pclk); while (!(m_req.psel && m_req.penable && m_rsp.pready));
		fault <= 1'b0;
		settle();
		apb(1'b0, STAT_OFS, 32'h0);
		cmp("error flag set", 32'h1, {31'h0, rd[STAT_ERR_BIT]});
		apb(1'b1, STAT_OFS, 32'h400);
		apb(1'b0, STAT_OFS, 32'h0);
		cmp("error flag cleared", 32'h0, {31'h0, rd[STAT_ERR_BIT]});
		cmp("device after retry", 32'h0, {28'h0, ovc});
		$display("test fault done");
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_unmapped();
		t_speeds();
		go(4'hc, 4'h0);
		t_supply();
		t_fault();
		test_done();
	end
endmodule // tb_hcv_ctrl
